// *** verilog/aep_pkg.sv ***
// Package for the acquisition error and ring pointer register block.
// Assumes a 32-bit AHB-Lite register bus; printed offsets are word indices.
package aep_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_ERROR      = 8'h22;
  localparam logic [7:0] IDX_START_LO   = 8'h24;
  localparam logic [7:0] IDX_START_HI   = 8'h26;
  localparam logic [7:0] IDX_END_LO     = 8'h28;
  localparam logic [7:0] IDX_END_HI     = 8'h2a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h32;

  localparam int ADDR_W = 10;

  // Error register fields
  localparam int ERR_CONT_BAD_BUFFER   = 5;
  localparam int ERR_CONT_BAD_COUNT    = 4;
  localparam int ERR_CAPT_SINGLE_ROW   = 2;
  localparam int ERR_CAPT_BAD_BUFFER   = 1;
  localparam int ERR_CAPT_BAD_COUNT    = 0;
  localparam logic [15:0] ERROR_RESET  = 16'h0000;
  localparam logic [15:0] PTR_RESET    = 16'h0000;

  // Interrupt status fields
  localparam int IRQ_W                = 2;
  localparam int IRQ_ABORT            = 0;
  localparam int IRQ_CAPT_DONE        = 1;
  localparam logic [1:0] IRQ_RESET    = 2'h0;

  // Ring geometry
  localparam int PTR_W                = 23;
  localparam logic [22:0] RING_LAST   = 23'h7fffff;
  localparam logic [4:0] MAX_CH_16    = 5'h10;
  localparam logic [4:0] MAX_CH_8     = 5'h08;

  typedef enum logic [1:0] {
    AEP_MODE_CONT,
    AEP_MODE_CAPT,
    AEP_MODE_OTHER
  } aep_mode_t;

  typedef enum {
    AEP_IDLE,
    AEP_CONT,
    AEP_CAPT
  } aep_state_t;

endpackage

// *** verilog/aep_regs.sv ***
// Acquisition error flags, transient-capture ring pointers, AHB-Lite slave.
// Assumes mode events, sample strobes and settings are synchronous to hclk.
`timescale 1ns/1ps

// Summary of operation
// - Clear error flags on entry, update before exit
// - Programming error aborts mode back to idle
// - Continuous mode: inconsistent buffer sets bit 5
// - Continuous mode: bad channel count sets bit 4
// - Capture mode: single-row buffer sets bit 2
// - Single-row check never applies to continuous mode
// - Capture mode: bit 5 check reported in bit 1
// - Capture mode: bit 4 check reported in bit 0
// - Start pointer is 23 bits, high and low
// - Start pointer names first captured sample
// - Start high holds address bits 22:16
// - Start low holds address bits 15:0
// - Sample buffer wraps as continuous ring
// - Pointers maintained only in capture mode
// - End pointer is 23 bits, high and low
// - End pointer names first closing-portion sample
// - End high holds address bits 22:16
// - End low holds bits 15:0, read-only
module aep_regs
  import aep_pkg::*;
(
  input  wire logic              hclk,             // Bus clock, 250 MHz
  input  wire logic              hresetn,          // Asynchronous reset, active low
  input  wire logic              hsel,             // Slave select
  input  wire logic [ADDR_W-1:0] haddr,            // Byte address
  input  wire logic [1:0]        htrans,           // Transfer type
  input  wire logic              hwrite,           // Write when high
  input  wire logic [2:0]        hsize,            // Transfer size
  input  wire logic [31:0]       hwdata,           // Write data
  input  wire logic              hready,           // Bus ready
  output logic      [31:0]       hrdata,           // Read data
  output logic                   hreadyout,        // Slave ready
  output logic                   hresp,            // Always OKAY
  input  wire logic              mode_enter,       // Pulse: enter mode_sel
  input  wire aep_mode_t         mode_sel,         // Mode being entered
  input  wire logic              mode_exit,        // Pulse: normal mode end
  input  wire logic [15:0]       buffer_rows,      // Buffer size in sample rows
  input  wire logic [15:0]       channel_enable,   // Enabled channel mask
  input  wire logic              board_16ch,       // High for a 16-channel board
  input  wire logic              sample_write,     // Pulse: one word stored to DRAM
  input  wire logic              store_trigger,    // Pulse: store trigger seen
  output logic      [PTR_W-1:0]  ring_write_addr,  // Current DRAM write address
  output logic                   mode_abort,       // Pulse: mode dropped to idle
  output logic                   mode_busy,        // Level: a mode is active
  output logic                   irq               // Level interrupt
);

  aep_state_t        state;
  logic [15:0]       error_flags;
  logic [PTR_W-1:0]  ring_start_addr;
  logic [PTR_W-1:0]  ring_end_addr;
  logic [PTR_W-1:0]  ring_limit;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [4:0]        enabled_count;
  logic              bad_count;
  logic              bad_buffer;
  logic              single_row;
  logic              check_fail;
  logic              addr_phase;
  logic              rd_take;
  logic              wr_take;
  logic [7:0]        word_index;
  logic [31:0]       next_rdata;
  logic              status_read;
  logic [PTR_W+4:0]  ring_words;

  // Enabled channel count
  always_comb begin
    enabled_count = 5'h00;
    for (int i = 0; i < 16; i++) begin
      enabled_count = enabled_count + {4'h0, channel_enable[i]};
    end
  end

  // Only powers of two up to the board width are legal
  always_comb begin
    bad_count = 1'b1;
    if (enabled_count == 5'h01 || enabled_count == 5'h02 || enabled_count == 5'h04 ||
        enabled_count == MAX_CH_8 || (board_16ch && enabled_count == MAX_CH_16)) begin
      bad_count = 1'b0;
    end
  end

  // Buffer must be nonempty and fit in the DRAM ring
  assign ring_words = 28'(buffer_rows * enabled_count);
  assign bad_buffer = (buffer_rows == 16'h0000) || (channel_enable == 16'h0000) ||
                      (ring_words > {5'h00, RING_LAST} + 28'h1) ||
                      (board_16ch == 1'b0 && channel_enable[15:8] != 8'h00);
  assign single_row = (buffer_rows == 16'h0001);
  assign ring_limit = (ring_words == 28'h0) ? 23'h0 : 23'(ring_words - 28'h1);

  // Single-row check only counts in capture mode
  always_comb begin
    check_fail = 1'b0;
    case (state)
      AEP_CONT: check_fail = bad_count | bad_buffer;
      AEP_CAPT: check_fail = bad_count | bad_buffer | single_row;
      default:  check_fail = 1'b0;
    endcase
  end

  // Mode sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= AEP_IDLE;
      mode_abort <= 1'b0;
    end else begin
      mode_abort <= 1'b0;
      case (state)
        AEP_IDLE: begin
          if (mode_enter && mode_sel == AEP_MODE_CONT) begin
            state <= AEP_CONT;
          end else if (mode_enter && mode_sel == AEP_MODE_CAPT) begin
            state <= AEP_CAPT;
          end
        end
        AEP_CONT, AEP_CAPT: begin
          if (check_fail) begin
            state      <= AEP_IDLE;
            mode_abort <= 1'b1;
          end else if (mode_exit) begin
            state <= AEP_IDLE;
          end
        end
        default: state <= AEP_IDLE;
      endcase
    end
  end

  assign mode_busy = (state != AEP_IDLE);

  // Error flags: cleared on entry, set while the mode is still active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_flags <= ERROR_RESET;
    end else if (state == AEP_IDLE && mode_enter) begin
      error_flags <= ERROR_RESET;
    end else if (state == AEP_CONT) begin
      error_flags[ERR_CONT_BAD_BUFFER] <= bad_buffer;
      error_flags[ERR_CONT_BAD_COUNT]  <= bad_count;
    end else if (state == AEP_CAPT) begin
      error_flags[ERR_CAPT_SINGLE_ROW] <= single_row;
      error_flags[ERR_CAPT_BAD_BUFFER] <= bad_buffer;
      error_flags[ERR_CAPT_BAD_COUNT]  <= bad_count;
    end
  end

  // Ring write address wraps at the configured buffer end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_write_addr <= '0;
    end else if (state == AEP_IDLE && mode_enter) begin
      ring_write_addr <= '0;
    end else if (state == AEP_CAPT && sample_write) begin
      if (ring_write_addr >= ring_limit) begin
        ring_write_addr <= '0;
      end else begin
        ring_write_addr <= ring_write_addr + 23'h1;
      end
    end
  end

  // End pointer marks the trigger; start pointer is the oldest word at close
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_end_addr <= '0;
    end else if (state == AEP_CAPT && store_trigger && !check_fail) begin
      ring_end_addr <= ring_write_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_start_addr <= '0;
    end else if (state == AEP_CAPT && mode_exit && !check_fail) begin
      ring_start_addr <= ring_write_addr;
    end
  end

  // Bus address phase
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_take    = addr_phase && !hwrite;
  assign wr_take    = addr_phase && hwrite;
  assign word_index = 8'(haddr[ADDR_W-1:2]);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign status_read = rd_take && word_index == IDX_IRQ_STATUS;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_index)
      IDX_ERROR:      next_rdata = {16'h0000, error_flags};
      IDX_START_LO:   next_rdata = {16'h0000, ring_start_addr[15:0]};
      IDX_START_HI:   next_rdata = {25'h0000000, ring_start_addr[22:16]};
      IDX_END_LO:     next_rdata = {16'h0000, ring_end_addr[15:0]};
      IDX_END_HI:     next_rdata = {25'h0000000, ring_end_addr[22:16]};
      IDX_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
      IDX_IRQ_MASK:   next_rdata = {30'h00000000, irq_mask};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= next_rdata;
    end
  end

  // Only the mask is writable; writes elsewhere are dropped
  logic              wr_pending;
  logic [7:0]        wr_index;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_index   <= 8'h00;
    end else begin
      wr_pending <= wr_take;
      if (wr_take) begin
        wr_index <= word_index;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= IRQ_RESET;
    end else if (wr_pending && wr_index == IDX_IRQ_MASK) begin
      irq_mask <= hwdata[IRQ_W-1:0];
    end
  end

  // Sticky events; a new event wins over the read clear
  logic [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_ABORT]     = mode_abort;
  assign irq_event[IRQ_CAPT_DONE] = (state == AEP_CAPT) && mode_exit && !check_fail;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= (status_read ? IRQ_RESET : irq_status) | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask);

  chk_abort_to_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (state != AEP_IDLE && check_fail) |=> (state == AEP_IDLE && mode_abort))
    else $error("error did not return the mode to idle");

  chk_abort_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_abort |-> (state == AEP_IDLE && $past(check_fail)))
    else $error("abort pulse without a failed check");

  chk_abort_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_abort |=> !mode_abort)
    else $error("abort pulse longer than one cycle");

  chk_abort_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_abort |=> irq_status[IRQ_ABORT])
    else $error("abort event not recorded in status");

  chk_entry_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_IDLE && mode_enter) |=> (error_flags == 16'h0000))
    else $error("error flags not cleared on mode entry");

  chk_enter_cont: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_IDLE && mode_enter && mode_sel == AEP_MODE_CONT) |=> (state == AEP_CONT))
    else $error("continuous mode not entered");

  chk_enter_capt: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_IDLE && mode_enter && mode_sel == AEP_MODE_CAPT) |=> (state == AEP_CAPT))
    else $error("capture mode not entered");

  chk_idle_flags_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_IDLE && !mode_enter) |=> $stable(error_flags))
    else $error("error flags changed while idle");

  chk_cont_count_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CONT && bad_count) |=> error_flags[ERR_CONT_BAD_COUNT])
    else $error("continuous channel count flag missing");

  chk_cont_buffer_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CONT && bad_buffer) |=> error_flags[ERR_CONT_BAD_BUFFER])
    else $error("continuous buffer flag missing");

  chk_cont_no_row: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CONT && single_row && !bad_count && !bad_buffer)
      |=> (state == AEP_CONT || $past(mode_exit)))
    else $error("single-row buffer aborted continuous mode");

  chk_cont_keeps_row: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CONT) |=> $stable(error_flags[ERR_CAPT_SINGLE_ROW]))
    else $error("single-row flag changed in continuous mode");

  chk_capt_row_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && single_row) |=> error_flags[ERR_CAPT_SINGLE_ROW])
    else $error("capture single-row flag missing");

  chk_capt_buffer_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && bad_buffer) |=> error_flags[ERR_CAPT_BAD_BUFFER])
    else $error("capture buffer flag missing");

  chk_capt_count_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && bad_count) |=> error_flags[ERR_CAPT_BAD_COUNT])
    else $error("capture channel count flag missing");

  chk_capt_keeps_cont: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT) |=> ($stable(error_flags[ERR_CONT_BAD_BUFFER]) &&
                             $stable(error_flags[ERR_CONT_BAD_COUNT])))
    else $error("continuous flags changed in capture mode");

  chk_ring_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && sample_write && ring_write_addr >= ring_limit && !mode_enter)
      |=> ring_write_addr == 23'h0)
    else $error("ring address did not wrap");

  chk_ring_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && sample_write && ring_write_addr < ring_limit)
      |=> (ring_write_addr == $past(ring_write_addr) + 23'h1))
    else $error("ring address did not advance");

  chk_ring_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sample_write && !(state == AEP_IDLE && mode_enter)) |=> $stable(ring_write_addr))
    else $error("ring address moved without a sample");

  chk_end_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && store_trigger && !check_fail)
      |=> ring_end_addr == $past(ring_write_addr))
    else $error("end pointer not taken at trigger");

  chk_start_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == AEP_CAPT && mode_exit && !check_fail)
      |=> (ring_start_addr == $past(ring_write_addr)))
    else $error("start pointer not taken at capture end");

  chk_ptr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state != AEP_CAPT) |=> $stable(ring_start_addr) && $stable(ring_end_addr))
    else $error("pointer changed outside capture mode");

  chk_start_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && word_index == IDX_START_HI)
      |=> hrdata == {25'h0000000, $past(ring_start_addr[22:16])})
    else $error("start high read wrong");

  chk_start_low_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && word_index == IDX_START_LO)
      |=> (hrdata == {16'h0000, $past(ring_start_addr[15:0])}))
    else $error("start low read wrong");

  chk_end_low_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && word_index == IDX_END_LO)
      |=> (hrdata == {16'h0000, $past(ring_end_addr[15:0])}))
    else $error("end low read wrong");

  chk_end_high_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && word_index == IDX_END_HI)
      |=> (hrdata == {25'h0000000, $past(ring_end_addr[22:16])}))
    else $error("end high read wrong");

  chk_error_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && word_index == IDX_ERROR) |=> (hrdata == {16'h0000, $past(error_flags)}))
    else $error("error register read wrong");

  chk_write_no_effect: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pending && state == AEP_IDLE && !mode_enter)
      |=> ($stable(error_flags) && $stable(ring_start_addr) && $stable(ring_end_addr)))
    else $error("register write changed read-only contents");

  chk_mask_write_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pending && wr_index != IDX_IRQ_MASK) |=> $stable(irq_mask))
    else $error("mask changed by a write elsewhere");

  chk_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pending && wr_index == IDX_IRQ_MASK) |=> (irq_mask == $past(hwdata[IRQ_W-1:0])))
    else $error("mask write not applied");

  chk_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (status_read && irq_event == '0)
      |=> irq_status == '0 ##1 (irq_status == '0 || $past(irq_event) != '0))
    else $error("status read did not clear");

endmodule

// *** tb/aep_regs_tb.sv ***
// Self-checking bench for the acquisition error and ring pointer register block.
// Assumes one 250 MHz clock; most scenarios model a 16-channel board.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin \
  $display("ERROR %s expected %h seen %h", nm, ex, sn); n_mismatch++; end end

module aep_regs_tb
  import aep_pkg::*;
;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  logic              mode_enter = 1'b0;
  logic              mode_exit = 1'b0;
  logic              sample_write = 1'b0;
  logic              store_trigger = 1'b0;
  logic              board_16ch = 1'b1;
  logic [15:0]       buffer_rows = 16'h0004;
  logic [15:0]       channel_enable = 16'h0001;
  aep_mode_t         mode_sel = AEP_MODE_CONT;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [PTR_W-1:0]  ring_write_addr;
  logic              mode_abort;
  logic              mode_busy;
  logic              irq;
  logic [31:0]       rd;
  logic [7:0]        idx_list [8];
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                n_abort = 0;

  always #2 hclk = ~hclk;

  always @(posedge hclk) begin
    if (mode_abort === 1'b1) n_abort++;
  end

  aep_regs i_aep_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_enter(mode_enter),
    .mode_sel(mode_sel), .mode_exit(mode_exit), .buffer_rows(buffer_rows),
    .channel_enable(channel_enable), .board_16ch(board_16ch),
    .sample_write(sample_write), .store_trigger(store_trigger),
    .ring_write_addr(ring_write_addr), .mode_abort(mode_abort),
    .mode_busy(mode_busy), .irq(irq)
  );

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        `CHK("hreadyout", 1'b1, hreadyout)
        final_report();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {idx, 2'b00};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] ex, input string nm);
    bus(1'b0, idx, 32'h0, rd);
    `CHK(nm, ex, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic reset_dut();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic pulse_enter(input aep_mode_t m);
    mode_sel   <= m;
    mode_enter <= 1'b1;
    @(posedge hclk);
    mode_enter <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (mode_busy !== 1'b0) begin
      k++;
      if (k > 20) begin
        `CHK("mode_busy", 1'b0, mode_busy)
        final_report();
      end
      @(posedge hclk);
    end
    `CHK("mode_busy", 1'b0, mode_busy)
  endtask

  // Entering the unsupported mode clears the flags but never goes busy
  task automatic other_mode();
    pulse_enter(AEP_MODE_OTHER);
    @(posedge hclk);
    `CHK("mode_busy", 1'b0, mode_busy)
    rd_chk(IDX_ERROR, 32'h0, "error after other entry");
  endtask

  // Enter a mode; a clean setup runs and exits, a bad one must abort
  task automatic run_mode(input aep_mode_t m, input logic [15:0] rows,
                          input logic [15:0] mask, input logic [15:0] exp_err);
    int a0;
    a0 = n_abort;
    buffer_rows    <= rows;
    channel_enable <= mask;
    @(posedge hclk);
    pulse_enter(m);
    repeat (4) @(posedge hclk);
    if (exp_err == 16'h0) begin
      `CHK("mode_busy", 1'b1, mode_busy)
      mode_exit <= 1'b1;
      @(posedge hclk);
      mode_exit <= 1'b0;
      @(posedge hclk);
    end
    wait_idle();
    `CHK("abort pulses", (exp_err != 16'h0) ? 1 : 0, n_abort - a0)
    rd_chk(IDX_ERROR, {16'h0, exp_err}, "error flags");
  endtask

  task automatic ptr_chk(input logic [22:0] e_start, input logic [22:0] e_end);
    rd_chk(IDX_START_LO, {16'h0, e_start[15:0]}, "start low");
    rd_chk(IDX_START_HI, {25'h0, e_start[22:16]}, "start high");
    rd_chk(IDX_END_LO, {16'h0, e_end[15:0]}, "end low");
    rd_chk(IDX_END_HI, {25'h0, e_end[22:16]}, "end high");
  endtask

  // Capture run: writes, store trigger, more writes, then normal exit
  task automatic capture(input logic [15:0] rows, input logic [15:0] mask, input int n1,
                         input int n2, input logic [22:0] e_start, input logic [22:0] e_end);
    reset_dut();
    buffer_rows    <= rows;
    channel_enable <= mask;
    @(posedge hclk);
    pulse_enter(AEP_MODE_CAPT);
    repeat (n1) begin
      sample_write <= 1'b1;
      @(posedge hclk);
    end
    sample_write  <= 1'b0;
    store_trigger <= 1'b1;
    @(posedge hclk);
    store_trigger <= 1'b0;
    repeat (n2) begin
      sample_write <= 1'b1;
      @(posedge hclk);
    end
    sample_write <= 1'b0;
    @(posedge hclk);
    `CHK("ring_write_addr", e_start, ring_write_addr)
    mode_exit <= 1'b1;
    @(posedge hclk);
    mode_exit <= 1'b0;
    @(posedge hclk);
    wait_idle();
    ptr_chk(e_start, e_end);
  endtask

  // Unmask the expected sticky bits, see the level, then clear by reading
  task automatic irq_chk(input logic [1:0] ex);
    bus(1'b1, IDX_IRQ_MASK, 32'h0, rd);
    repeat (2) @(posedge hclk);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, IDX_IRQ_MASK, {30'h0, ex}, rd);
    repeat (2) @(posedge hclk);
    `CHK("irq raised", 1'b1, irq)
    rd_chk(IDX_IRQ_MASK, {30'h0, ex}, "irq mask");
    rd_chk(IDX_IRQ_STATUS, {30'h0, ex}, "irq status");
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(IDX_IRQ_STATUS, 32'h0, "irq status after read");
  endtask

  task automatic writes_ignored();
    foreach (idx_list[i]) begin
      if (i < 5) bus(1'b1, idx_list[i], 32'hffff_ffff, rd);
    end
    rd_chk(IDX_ERROR, 32'h0, "error after write");
    ptr_chk(23'h000001, 23'h000002);
  endtask

  initial begin
    idx_list = '{IDX_ERROR, IDX_START_LO, IDX_START_HI, IDX_END_LO, IDX_END_HI,
                 IDX_IRQ_STATUS, IDX_IRQ_MASK, 8'h3f};
    reset_dut();
    foreach (idx_list[i]) rd_chk(idx_list[i], 32'h0, "reset value");
    run_mode(AEP_MODE_CONT, 16'h0004, 16'h0007, 16'h0010);
    run_mode(AEP_MODE_CONT, 16'h0000, 16'h0001, 16'h0020);
    run_mode(AEP_MODE_CONT, 16'h0001, 16'h0001, 16'h0000);
    run_mode(AEP_MODE_CAPT, 16'h0001, 16'h0001, 16'h0004);
    run_mode(AEP_MODE_CAPT, 16'h0000, 16'h0001, 16'h0002);
    run_mode(AEP_MODE_CAPT, 16'h0004, 16'h0007, 16'h0001);
    other_mode();
    board_16ch <= 1'b0;
    run_mode(AEP_MODE_CONT, 16'h0004, 16'hffff, 16'h0030);
    run_mode(AEP_MODE_CONT, 16'h0004, 16'h00ff, 16'h0000);
    board_16ch <= 1'b1;
    run_mode(AEP_MODE_CAPT, 16'h0004, 16'h00ff, 16'h0000);
    irq_chk(2'h3);
    capture(16'h0004, 16'h0001, 6, 3, 23'h000001, 23'h000002);
    irq_chk(2'h2);
    writes_ignored();
    capture(16'h2000, 16'hffff, 32'h10005, 3, 23'h010008, 23'h010005);
    final_report();
  end

endmodule
